// file: verilog/acc_adc_control.sv
// conversion control of a ten bit successive approximation converter
module acc_adc_control #(
  parameter int TRIG_N = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [acc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [acc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [acc_pkg::DATA_W-1:0] rdata_out,
  // trigger source levels, bit zero unused
  input wire logic [TRIG_N-1:0] trig_in,
  // analog array
  input wire logic [acc_pkg::RES_W-1:0] result_in,
  output logic analog_en_out,
  output logic convert_out,
  output logic sample_out,
  output logic [acc_pkg::CH_W-1:0] chan_out,
  output logic [acc_pkg::REF_W-1:0] ref_out,
  // completion request
  output logic irq_out
);
  if (TRIG_N < 2 || TRIG_N > 8) begin : g_chk
    $error("acc_adc_control: TRIG_N must be 2 to 8");
  end

  // unsupported codes fall back to ground
  function automatic logic [acc_pkg::CH_W-1:0] acc_chan_map(
    input logic [acc_pkg::CH_W-1:0] ch
  );
    if (ch < acc_pkg::CH_PINS || ch == acc_pkg::CH_BANDGAP) begin
      acc_chan_map = ch;
    end else begin
      acc_chan_map = acc_pkg::CH_GROUND;
    end
  endfunction : acc_chan_map

  // low result byte for either alignment
  function automatic logic [7:0] acc_byte_lo(
    input logic [acc_pkg::RES_W-1:0] r,
    input logic left
  );
    acc_byte_lo = left ? {r[1:0], 6'h00} : r[7:0];
  endfunction : acc_byte_lo

  // high result byte for either alignment
  function automatic logic [7:0] acc_byte_hi(
    input logic [acc_pkg::RES_W-1:0] r,
    input logic left
  );
    acc_byte_hi = left ? r[9:2] : {6'h00, r[9:8]};
  endfunction : acc_byte_hi

  // software state
  logic en_q;
  logic auto_q;
  logic flag_q;
  logic ie_q;
  logic pr_q;
  logic left_q;
  logic [acc_pkg::PS_W-1:0] ps_q;
  logic [acc_pkg::TS_W-1:0] ts_q;
  logic [acc_pkg::CH_W-1:0] ch_q;
  logic [acc_pkg::REF_W-1:0] ref_q;
  logic [acc_pkg::RES_W-1:0] res_q;
  logic lock_q;
  // sequencer
  acc_pkg::acc_state_t state_q;
  acc_pkg::acc_state_t state_d;
  logic [acc_pkg::CNT_W-1:0] cnt_q;
  logic [acc_pkg::CNT_W-1:0] cnt_d;
  logic first_q;
  logic act_prev_q;
  // trigger path
  logic [TRIG_N-1:0] s1_q;
  logic [TRIG_N-1:0] s2_q;
  logic [TRIG_N-1:0] s3_q;
  logic [TRIG_N-1:0] lvl_q;
  logic [TRIG_N-1:0] lvl_d;
  logic sel_prev_q;
  logic sel_lvl;
  logic trig_edge;

  // decoded strobes
  logic wr_a;
  logic wr_b;
  logic wr_is;
  logic wr_pw;
  logic rd_lo;
  logic rd_hi;
  assign wr_a = wr_in && addr_in == acc_pkg::REG_CTRL_A;
  assign wr_b = wr_in && addr_in == acc_pkg::REG_CTRL_B;
  assign wr_is = wr_in && addr_in == acc_pkg::REG_INSEL;
  assign wr_pw = wr_in && addr_in == acc_pkg::REG_POWER;
  assign rd_lo = rd_in && addr_in == acc_pkg::REG_RES_LO;
  assign rd_hi = rd_in && addr_in == acc_pkg::REG_RES_HI;

  // sequencer terms
  logic act;
  logic idle;
  logic tick;
  logic freerun;
  logic sw_start;
  logic trig_go;
  logic done_evt;
  logic [acc_pkg::CNT_W-1:0] len;
  logic [acc_pkg::CNT_W-1:0] shpt;
  assign act = en_q && !pr_q;
  assign idle = state_q == acc_pkg::ST_IDLE;
  assign freerun = auto_q && ts_q == acc_pkg::TS_FREE;
  assign sw_start = wr_a && wdata_in[acc_pkg::A_START] && act;
  assign trig_go = auto_q && act && idle && trig_edge;
  assign len = first_q ? acc_pkg::TICKS_FIRST : acc_pkg::TICKS_NORMAL;
  assign shpt = first_q ? acc_pkg::SH_FIRST : acc_pkg::SH_NORMAL;
  assign done_evt = state_q == acc_pkg::ST_CONV && tick &&
                    cnt_q == len - acc_pkg::CNT_ONE;

  // converter clock, cleared on a trigger start
  acc_prescaler #(
    .DIV_W(8)
  ) u_presc (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .run_in(act),
    .clear_in(trig_go),
    .sel_in(ps_q),
    .tick_out(tick)
  );

  // trigger level filter: change taken once stages two and three agree
  assign lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
  // own done flag is on this clock and needs no filter
  assign sel_lvl = (ts_q == acc_pkg::TS_FREE) ? flag_q :
                   (32'(ts_q) < TRIG_N) ? lvl_q[ts_q] : 1'b0;
  assign trig_edge = sel_lvl && !sel_prev_q;

  // trigger synchroniser and edge history
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
      sel_prev_q <= 1'b0;
    end else begin
      s1_q <= trig_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      sel_prev_q <= sel_lvl;
    end
  end

  // next state of the conversion sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      acc_pkg::ST_IDLE: begin
        if (trig_go) begin
          state_d = acc_pkg::ST_CONV;
          cnt_d = '0;
        end else if (sw_start) begin
          state_d = acc_pkg::ST_WAIT;
        end
      end
      acc_pkg::ST_WAIT: begin
        if (tick) begin
          state_d = acc_pkg::ST_CONV;
          cnt_d = '0;
        end
      end
      acc_pkg::ST_CONV: begin
        if (done_evt) begin
          cnt_d = '0;
          if (freerun) begin
            state_d = acc_pkg::ST_CONV;
          end else begin
            state_d = acc_pkg::ST_IDLE;
          end
        end else if (tick) begin
          cnt_d = cnt_q + acc_pkg::CNT_ONE;
        end
      end
      default: begin
        state_d = acc_pkg::ST_IDLE;
        cnt_d = '0;
      end
    endcase
    if (!act) begin
      state_d = acc_pkg::ST_IDLE;
      cnt_d = '0;
    end
  end

  // sequencer registers and first conversion marker
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= acc_pkg::ST_IDLE;
      cnt_q <= '0;
      act_prev_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      act_prev_q <= act;
      if (act && !act_prev_q) begin
        first_q <= 1'b1;
      end else if (done_evt) begin
        first_q <= 1'b0;
      end
    end
  end

  // control a and power register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      en_q <= 1'b0;
      auto_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= '0;
      pr_q <= acc_pkg::PR_RESET;
    end else begin
      if (wr_a) begin
        en_q <= wdata_in[acc_pkg::A_EN];
        auto_q <= wdata_in[acc_pkg::A_AUTO];
        ie_q <= wdata_in[acc_pkg::A_IE];
        ps_q <= wdata_in[acc_pkg::A_PS +: acc_pkg::PS_W];
      end
      if (wr_pw) begin
        pr_q <= wdata_in[acc_pkg::PW_PR];
      end
    end
  end

  // done flag: set on completion wins over a write one clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flag_q <= 1'b0;
    end else if (done_evt) begin
      flag_q <= 1'b1;
    end else if (wr_a && wdata_in[acc_pkg::A_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // control b and input select register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ts_q <= '0;
      ch_q <= '0;
      ref_q <= '0;
      left_q <= 1'b0;
    end else begin
      if (wr_b) begin
        ts_q <= wdata_in[acc_pkg::B_TS +: acc_pkg::TS_W];
      end
      if (wr_is) begin
        ch_q <= wdata_in[acc_pkg::IS_CH +: acc_pkg::CH_W];
        ref_q <= wdata_in[acc_pkg::IS_REF +: acc_pkg::REF_W];
        left_q <= wdata_in[acc_pkg::IS_LEFT];
      end
    end
  end

  // result capture and read lock
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      res_q <= '0;
      lock_q <= 1'b0;
    end else begin
      if (done_evt && !lock_q) begin
        res_q <= result_in;
      end
      if (rd_lo) begin
        lock_q <= 1'b1;
      end else if (rd_hi) begin
        lock_q <= 1'b0;
      end
    end
  end

  // register read data
  logic [acc_pkg::DATA_W-1:0] rd_mux;
  logic [acc_pkg::DATA_W-1:0] ctrl_a_rd;
  assign ctrl_a_rd = {en_q, !idle, auto_q, flag_q, ie_q, ps_q};
  assign rd_mux =
    (addr_in == acc_pkg::REG_CTRL_A) ? ctrl_a_rd :
    (addr_in == acc_pkg::REG_CTRL_B) ? {5'h00, ts_q} :
    (addr_in == acc_pkg::REG_INSEL) ? {ref_q, left_q, 1'b0, ch_q} :
    (addr_in == acc_pkg::REG_RES_LO) ? acc_byte_lo(res_q, left_q) :
    (addr_in == acc_pkg::REG_RES_HI) ? acc_byte_hi(res_q, left_q) :
    (addr_in == acc_pkg::REG_POWER) ? {7'h00, pr_q} : 8'h00;

  // read data stands for one cycle only
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= rd_in ? rd_mux : 8'h00;
    end
  end

  // analog side: selections held while converting, applied when enabled
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      chan_out <= acc_pkg::CH_GROUND;
      ref_out <= '0;
      analog_en_out <= 1'b0;
      convert_out <= 1'b0;
      sample_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (act && state_q != acc_pkg::ST_CONV) begin
        chan_out <= acc_chan_map(ch_q);
        ref_out <= ref_q;
      end
      analog_en_out <= act;
      convert_out <= state_d == acc_pkg::ST_CONV;
      sample_out <= state_q == acc_pkg::ST_CONV && tick && cnt_q == shpt;
      irq_out <= flag_q && ie_q;
    end
  end

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_lo_read;
    rd_in && addr_in == acc_pkg::REG_RES_LO;
  endsequence
  sequence s_blocked_done;
    lock_q && done_evt;
  endsequence
  sequence s_conv_twice;
    state_q == acc_pkg::ST_CONV ##1 state_q == acc_pkg::ST_CONV;
  endsequence

  a_lo_read_locks: assert property (s_lo_read |=> lock_q)
    else $error("low byte read did not lock results");
  a_lock_blocks_update: assert property (
    s_blocked_done |=> res_q == $past(res_q))
    else $error("blocked result was written");
  a_hi_read_unlocks: assert property (
    rd_in && addr_in == acc_pkg::REG_RES_HI |=> !lock_q)
    else $error("high byte read did not unlock");
  a_done_sets_flag: assert property (done_evt |=> flag_q)
    else $error("done flag not set on completion");
  a_power_holds_idle: assert property (
    pr_q |=> state_q == acc_pkg::ST_IDLE && !analog_en_out)
    else $error("converter active under power reduce");
  a_chan_held: assert property (s_conv_twice |-> $stable(chan_out))
    else $error("channel changed during conversion");
  a_single_ends: assert property (
    done_evt && !freerun |=> state_q == acc_pkg::ST_IDLE && !convert_out)
    else $error("single conversion did not end");
  a_free_restart: assert property (
    done_evt && freerun && act |=> state_q == acc_pkg::ST_CONV &&
    cnt_q == '0)
    else $error("free running conversion did not restart");
  a_trig_start: assert property (
    trig_go |=> state_q == acc_pkg::ST_CONV && convert_out)
    else $error("trigger edge did not start conversion");
  a_irq_follows: assert property (flag_q && ie_q |=> irq_out)
    else $error("interrupt request missing");
endmodule : acc_adc_control

// file: verilog/acc_pkg.sv
// constants and types of the converter control block
package acc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int PS_W = 3;
  localparam int TS_W = 3;
  localparam int CH_W = 4;
  localparam int REF_W = 2;
  localparam int CNT_W = 5;
  // register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL_A = 3'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL_B = 3'h1;
  localparam logic [ADDR_W-1:0] REG_INSEL = 3'h2;
  localparam logic [ADDR_W-1:0] REG_RES_LO = 3'h3;
  localparam logic [ADDR_W-1:0] REG_RES_HI = 3'h4;
  localparam logic [ADDR_W-1:0] REG_POWER = 3'h5;
  // control a fields
  localparam int A_EN = 7;
  localparam int A_START = 6;
  localparam int A_AUTO = 5;
  localparam int A_FLAG = 4;
  localparam int A_IE = 3;
  localparam int A_PS = 0;
  // control b, input select and power fields
  localparam int B_TS = 0;
  localparam int IS_REF = 6;
  localparam int IS_LEFT = 5;
  localparam int IS_CH = 0;
  localparam int PW_PR = 0;
  localparam logic PR_RESET = 1'b0;
  // trigger source that is the converter's own done flag
  localparam logic [TS_W-1:0] TS_FREE = 3'h0;
  // channel codes
  localparam logic [CH_W-1:0] CH_PINS = 4'h8;
  localparam logic [CH_W-1:0] CH_BANDGAP = 4'he;
  localparam logic [CH_W-1:0] CH_GROUND = 4'hf;
  // conversion lengths and sample points in converter clocks
  localparam logic [CNT_W-1:0] TICKS_NORMAL = 5'hd;
  localparam logic [CNT_W-1:0] TICKS_FIRST = 5'h19;
  localparam logic [CNT_W-1:0] SH_NORMAL = 5'h1;
  localparam logic [CNT_W-1:0] SH_FIRST = 5'hd;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h1;
  // conversion sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } acc_state_t;
endpackage : acc_pkg

// file: verilog/acc_prescaler.sv
// converter clock prescaler giving a one cycle tick
module acc_prescaler #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // control
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic [2:0] sel_in,
  // tick
  output logic tick_out
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic [DIV_W-1:0] mask;
  logic wrap;

  // the slowest setting counts 256 clocks and needs eight bits
  if (DIV_W < 8) begin : g_chk
    $error("acc_prescaler: DIV_W must be at least 8");
  end

  // division by two to the power sel plus one
  assign mask = DIV_W'((8'h2 << sel_in) - 8'h1);
  assign wrap = &(cnt_q | ~mask);
  assign cnt_d = (run_in && !clear_in) ? cnt_q + DIV_W'(1) : '0;

  // counter held cleared while not running
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_out <= run_in && !clear_in && wrap;
    end
  end
endmodule : acc_prescaler

// file: sim/acc_array_model.sv
// behavioural analog array giving a fixed code per sampled channel
module acc_array_model (
  // clock
  input wire logic clk_in,
  // control from the converter
  input wire logic en_in,
  input wire logic sample_in,
  input wire logic [acc_pkg::CH_W-1:0] chan_in,
  // conversion code
  output logic [acc_pkg::RES_W-1:0] result_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [acc_pkg::RES_W-1:0] held_q = 10'h000;
  // hold the code of the channel seen at the sample pulse
  always @(posedge clk_in) begin
    if (en_in && sample_in) begin
      if (chan_in == 4'hf) held_q <= 10'h000;
      else held_q <= {chan_in, 6'h2d};
    end
  end
  // a powered-down array does not keep its last code on the lines
  assign result_out = en_in ? held_q : ~held_q;
endmodule : acc_array_model

// file: sim/acc_adc_control_bench.sv
// self-checking bench of the converter control block
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module acc_adc_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] trig_in = 8'h00;
  logic [7:0] rdata_out;
  logic [7:0] d;
  logic [9:0] result_in;
  logic [3:0] chan_out;
  logic [1:0] ref_out;
  logic analog_en_out, convert_out, sample_out, irq_out;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int run_len = 0;
  int last_len = 0;
  int n_samp = 0;
  int base;

  acc_adc_control #(.TRIG_N(8)) DUT (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .trig_in(trig_in), .result_in(result_in),
    .analog_en_out(analog_en_out), .convert_out(convert_out),
    .sample_out(sample_out), .chan_out(chan_out), .ref_out(ref_out),
    .irq_out(irq_out));

  acc_array_model array (.clk_in(clk_in), .en_in(analog_en_out),
    .sample_in(sample_out), .chan_in(chan_out), .result_out(result_in));

  // closing report
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // register write: one strobe cycle, then one idle cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  // register read: data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    d = rdata_out;
  endtask : rd

  // read and compare
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    `CHK("read data", e, d)
  endtask : rdc

  // poll the done flag under a bound
  task automatic wait_flag();
    int i;
    i = 0;
    d = 8'h00;
    while (d[4] !== 1'b1 && i < 200) begin
      rd(acc_pkg::REG_CTRL_A);
      i++;
    end
    `CHK("done flag", 1'b1, d[4])
  endtask : wait_flag

  // last conversion length in system clocks, two cycles of slack
  task automatic chk_len(input int n);
    `CHK("conversion length", 1'b1, last_len >= n - 2 && last_len <= n + 2)
  endtask : chk_len

  // clock
  initial begin
    forever #25 clk_in = ~clk_in;
  end

  // conversion length, sample count and run limit
  always @(posedge clk_in) begin
    cyc++;
    if (sample_out) n_samp++;
    if (convert_out) run_len++;
    else if (run_len != 0) begin
      last_len = run_len;
      run_len = 0;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // test sequence
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    // reset state and an unmapped place
    rdc(acc_pkg::REG_CTRL_A, 8'h00);
    rdc(acc_pkg::REG_POWER, 8'h00);
    rdc(3'h6, 8'h00);
    `CHK("channel", 4'hf, chan_out)
    // power reduce keeps the converter off
    wr(acc_pkg::REG_POWER, 8'h01);
    wr(acc_pkg::REG_CTRL_A, 8'hc0);
    repeat (4) @(posedge clk_in);
    `CHK("enable", 1'b0, analog_en_out)
    rdc(acc_pkg::REG_CTRL_A, 8'h80);
    wr(acc_pkg::REG_CTRL_A, 8'h00);
    wr(acc_pkg::REG_POWER, 8'h00);
    // selections wait for the enable bit
    wr(acc_pkg::REG_INSEL, 8'h43);
    repeat (2) @(posedge clk_in);
    `CHK("channel", 4'hf, chan_out)
    `CHK("reference", 2'h0, ref_out)
    wr(acc_pkg::REG_CTRL_A, 8'h80);
    repeat (2) @(posedge clk_in);
    `CHK("channel", 4'h3, chan_out)
    `CHK("reference", 2'h1, ref_out)
    // first conversion after enable, right aligned
    wr(acc_pkg::REG_CTRL_A, 8'hc0);
    rdc(acc_pkg::REG_CTRL_A, 8'hc0);
    wait_flag();
    chk_len(50);
    rdc(acc_pkg::REG_CTRL_A, 8'h90);
    rdc(acc_pkg::REG_RES_LO, 8'hed);
    rdc(acc_pkg::REG_RES_HI, 8'h00);
    // normal conversion, then left aligned read back
    wr(acc_pkg::REG_CTRL_A, 8'hd0);
    wait_flag();
    chk_len(26);
    wr(acc_pkg::REG_INSEL, 8'h63);
    rdc(acc_pkg::REG_RES_HI, 8'h3b);
    rdc(acc_pkg::REG_RES_LO, 8'h40);
    rdc(acc_pkg::REG_RES_HI, 8'h3b);
    // low read locks; a blocked result is lost but still flagged
    wr(acc_pkg::REG_INSEL, 8'h45);
    rdc(acc_pkg::REG_RES_LO, 8'hed);
    wr(acc_pkg::REG_CTRL_A, 8'hd0);
    repeat (4) @(posedge clk_in);
    wr(acc_pkg::REG_INSEL, 8'h46);
    repeat (2) @(posedge clk_in);
    `CHK("channel", 4'h5, chan_out)
    wait_flag();
    repeat (2) @(posedge clk_in);
    `CHK("channel", 4'h6, chan_out)
    rdc(acc_pkg::REG_RES_HI, 8'h00);
    wr(acc_pkg::REG_CTRL_A, 8'hd0);
    wait_flag();
    rdc(acc_pkg::REG_RES_LO, 8'had);
    rdc(acc_pkg::REG_RES_HI, 8'h01);
    // completion request follows flag and its enable
    `CHK("irq", 1'b0, irq_out)
    wr(acc_pkg::REG_CTRL_A, 8'h88);
    repeat (2) @(posedge clk_in);
    `CHK("irq", 1'b1, irq_out)
    wr(acc_pkg::REG_CTRL_A, 8'h98);
    repeat (2) @(posedge clk_in);
    `CHK("irq", 1'b0, irq_out)
    // channel codes: pins, bandgap, ground, unused codes to ground
    for (int c = 0; c < 16; c++) begin
      wr(acc_pkg::REG_INSEL, {4'h4, c[3:0]});
      repeat (2) @(posedge clk_in);
      `CHK("channel", (c < 8 || c == 14) ? c[3:0] : 4'hf, chan_out)
    end
    // trigger edge ignored while auto trigger is off
    wr(acc_pkg::REG_CTRL_B, 8'h01);
    base = n_samp;
    trig_in[1] <= 1'b1;
    repeat (40) @(posedge clk_in);
    `CHK("samples", base, n_samp)
    trig_in[1] <= 1'b0;
    wr(acc_pkg::REG_CTRL_A, 8'hb0);
    trig_in[1] <= 1'b1;
    repeat (10) @(posedge clk_in);
    `CHK("busy", 1'b1, convert_out)
    rdc(acc_pkg::REG_CTRL_A, 8'he0);
    trig_in[1] <= 1'b0;
    repeat (4) @(posedge clk_in);
    trig_in[1] <= 1'b1;
    wait_flag();
    repeat (60) @(posedge clk_in);
    `CHK("samples", base + 1, n_samp)
    rdc(acc_pkg::REG_RES_LO, 8'h00);
    rdc(acc_pkg::REG_RES_HI, 8'h00);
    trig_in[1] <= 1'b0;
    // start write still works under auto trigger, slower prescale
    wr(acc_pkg::REG_CTRL_A, 8'hf1);
    wait_flag();
    chk_len(52);
    // own flag as trigger converts on with the flag left set
    // flag cleared first so switching the source makes no trigger edge
    wr(acc_pkg::REG_CTRL_A, 8'hb0);
    wr(acc_pkg::REG_CTRL_B, 8'h00);
    base = n_samp;
    wr(acc_pkg::REG_CTRL_A, 8'he0);
    repeat (200) @(posedge clk_in);
    `CHK("free run", 1'b1, n_samp - base >= 6)
    rdc(acc_pkg::REG_CTRL_A, 8'hf0);
    // disable stops everything; next start is a first conversion
    wr(acc_pkg::REG_CTRL_A, 8'h10);
    repeat (2) @(posedge clk_in);
    `CHK("enable", 1'b0, analog_en_out)
    `CHK("busy", 1'b0, convert_out)
    // start is only taken once the enable bit already stands
    wr(acc_pkg::REG_CTRL_A, 8'h80);
    wr(acc_pkg::REG_CTRL_A, 8'hd0);
    wait_flag();
    chk_len(50);
    print_verdict();
  end
endmodule : acc_adc_control_bench
